// >>> inc/sdwp_pkg.sv
// Purpose: Shared constants and types for the write-burst memory core.
// Assumes: One 125 MHz clock, x8 organisation, four banks.
// Notes: Times are kept in ns and turned into clock counts here.

package sdwp_pkg;

	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int ROW_W = 12;
	localparam int COL_W = 10;
	localparam int BANK_W = 2;
	localparam int DATA_W = 8;
	localparam int NUM_BANKS = 4;
	localparam int AP_BIT = 10;
	localparam int BL_W = 3;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int WR_EXTRA_NS = 7;
	localparam int WR_REC_CYC =
		1 + (WR_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ROW_PRE_NS = 20;
	localparam int ROW_PRE_CYC =
		(ROW_PRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 3;
	localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
	localparam logic [CNT_W-1:0] ROW_PRE_LOAD = CNT_W'(ROW_PRE_CYC);

	// ------------------------------------------------------------
	// Burst length codes and column masks
	// ------------------------------------------------------------
	localparam logic [BL_W-1:0] BL_1 = 3'h0;
	localparam logic [BL_W-1:0] BL_2 = 3'h1;
	localparam logic [BL_W-1:0] BL_4 = 3'h2;
	localparam logic [BL_W-1:0] BL_8 = 3'h3;
	localparam logic [BL_W-1:0] BL_PAGE = 3'h7;
	localparam logic [COL_W-1:0] MASK_1 = 10'h000;
	localparam logic [COL_W-1:0] MASK_2 = 10'h001;
	localparam logic [COL_W-1:0] MASK_4 = 10'h003;
	localparam logic [COL_W-1:0] MASK_8 = 10'h007;
	localparam logic [COL_W-1:0] MASK_PAGE = 10'h3FF;
	localparam logic [COL_W-1:0] COL_ZERO = 10'h000;
	localparam logic [COL_W-1:0] COL_ONE = 10'h001;
	localparam logic [COL_W-1:0] COL_LAST = 10'h3FF;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		CMD_MODE = 3'h0,
		CMD_REFRESH = 3'h1,
		CMD_PRECHARGE = 3'h2,
		CMD_ACTIVE = 3'h3,
		CMD_WRITE = 3'h4,
		CMD_READ = 3'h5,
		CMD_TERMINATE = 3'h6,
		CMD_NOP = 3'h7
	} sdwp_cmd_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_BURST = 2'h1,
		ST_PDOWN = 2'h2
	} sdwp_state_e;

endpackage

// >>> rtl/sdwp_recovery_timer.sv
// Purpose: Counts the write recovery interval before an auto precharge.
// Assumes: Free-running clock; start is a one-cycle pulse.
// Notes: done_o pulses on the edge where the precharge may begin.

`timescale 1ns/10ps
module sdwp_recovery_timer #(
	parameter int CYC = 2
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	output logic done_o
);

	localparam logic [sdwp_pkg::CNT_W-1:0] LOAD = sdwp_pkg::CNT_W'(CYC);

	logic [sdwp_pkg::CNT_W-1:0] cnt_reg;
	logic [sdwp_pkg::CNT_W-1:0] cnt_next;

	// Load on start, then count down to zero.
	always_comb
	begin
		cnt_next = cnt_reg;
		if (start_i)
			cnt_next = LOAD;
		else if (cnt_reg != sdwp_pkg::CNT_ZERO)
			cnt_next = cnt_reg - sdwp_pkg::CNT_ONE;
	end

	// Counter register.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			cnt_reg <= sdwp_pkg::CNT_ZERO;
		else
			cnt_reg <= cnt_next;
	end

	// The last counted cycle releases the precharge.
	assign done_o = (cnt_reg == sdwp_pkg::CNT_ONE);

endmodule

// >>> rtl/sdwp_write_core.sv
// Purpose: Device-side write burst, precharge and power-down logic.
// Assumes: Controller pins are on SYS_CLK_I; writes leave on a store port.
// Notes: Read data is not produced, so the data pins never drive.
// Notes on behaviour
// R1: WRITE gives bank, column and auto-precharge; precharge follows the burst.
// R2: First word is taken with WRITE; later words on each following edge.
// R3: After a fixed burst ends, pins stay undriven and data is ignored.
// R4: Full-page bursts run until stopped and wrap to column zero.
// R5: A new WRITE on any edge cuts the old burst and owns its data.
// R6: READ stops the write burst; its edge and later data are dropped.
// R7: Controller waits write recovery before a PRECHARGE ending a burst.
// R8: Auto precharge waits one clock plus extra time after last data.
// R9: Controller masks data on the edge before and at a PRECHARGE.
// R10: Controller waits row precharge time before using that bank again.
// R11: BURST TERMINATE ends a burst; data on its edge is dropped.
// R12: Last stored word is the one an edge before BURST TERMINATE.
// R13: Clock-enable low during a burst freezes the internal state.
// R14: Each low clock-enable suspends the next edge; nothing advances then.
// R15: Clock-enable high ends suspend; work resumes on the next edge.
// R16: PRECHARGE closes one bank, or all when the all-bank bit is high.
// R17: A precharged bank takes no WRITE until it is activated again.
// R18: Clock-enable low with NOP while idle enters power-down.
// R19: Power-down with any open row is active power-down; rows stay open.
// R20: In power-down every input except clock-enable is ignored; the exit here also needs a NOP on the strobes.
// R21: Controller keeps power-down shorter than the refresh period.
// R22: NOP with clock-enable high leaves power-down.
// R23: Byte mask high on a capture edge blocks that word, no latency.
// R24: ACTIVE opens a row in a bank before access.
// R25: Commands decode from the four strobes on each enabled edge.

`timescale 1ns/10ps
module sdwp_write_core (
	input wire logic SYS_CLK_I,
	input wire logic RESETN_I,
	input wire logic CKE_I,
	input wire logic CS_N_I,
	input wire logic RAS_N_I,
	input wire logic CAS_N_I,
	input wire logic WE_N_I,
	input wire logic [1:0] BANK_I,
	input wire logic [11:0] ADDR_I,
	input wire logic DQM_I,
	input wire logic [7:0] DQ_I,
	input wire logic [2:0] BURST_LEN_I,
	output logic [7:0] DQ_O,
	output logic DQ_OE_O,
	output logic MEM_WE_O,
	output logic [1:0] MEM_BANK_O,
	output logic [11:0] MEM_ROW_O,
	output logic [9:0] MEM_COL_O,
	output logic [7:0] MEM_DATA_O,
	output logic [3:0] BANK_OPEN_O,
	output logic SUSPEND_O,
	output logic PDOWN_O,
	output logic PDOWN_ACTIVE_O,
	output logic CMD_REJECT_O
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	localparam int BW = sdwp_pkg::BANK_W;
	localparam int CW = sdwp_pkg::COL_W;
	localparam int RW = sdwp_pkg::ROW_W;
	localparam int DW = sdwp_pkg::DATA_W;
	localparam int NB = sdwp_pkg::NUM_BANKS;

	logic rst_meta_reg;
	logic rst_n_reg;
	logic cke_prev_reg;
	logic edge_en;
	logic live;
	logic all_sel;
	logic any_open;
	logic [CW-1:0] addr_col;
	sdwp_pkg::sdwp_cmd_e cmd;
	sdwp_pkg::sdwp_state_e st_reg, st_next;
	logic [BW-1:0] bank_reg, bank_next;
	logic [CW-1:0] col_reg, col_next;
	logic [CW-1:0] rem_reg, rem_next;
	logic [CW-1:0] mask_reg, mask_next;
	logic full_reg, full_next;
	logic ap_reg, ap_next;
	logic [BW-1:0] ap_bank_reg, ap_bank_next;
	logic pd_act_reg, pd_act_next;
	logic susp_reg, susp_next;
	logic reject_reg, reject_next;
	logic we_reg, we_next;
	logic [BW-1:0] wbank_reg, wbank_next;
	logic [RW-1:0] wrow_reg, wrow_next;
	logic [CW-1:0] wcol_reg, wcol_next;
	logic [DW-1:0] wdata_reg, wdata_next;
	logic word_go;
	logic [BW-1:0] word_bank;
	logic [CW-1:0] word_col;
	logic rec_start;
	logic rec_done;
	logic pre_req;
	logic act_req;
	logic [NB-1:0] bank_open;
	logic [NB-1:0] bank_busy;
	logic [RW-1:0] bank_row [NB];

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	// Turns the strobes into a command; a deselect acts as a NOP.
	function automatic sdwp_pkg::sdwp_cmd_e cmd_decode(
		input logic cs_n, input logic ras_n,
		input logic cas_n, input logic we_n);
		if (cs_n)
			return sdwp_pkg::CMD_NOP;
		return sdwp_pkg::sdwp_cmd_e'({ras_n, cas_n, we_n});
	endfunction

	// Column mask of the burst length code; zero for reserved codes.
	function automatic logic [CW-1:0] bl_mask(input logic [2:0] code);
		unique case (code)
			sdwp_pkg::BL_2: return sdwp_pkg::MASK_2;
			sdwp_pkg::BL_4: return sdwp_pkg::MASK_4;
			sdwp_pkg::BL_8: return sdwp_pkg::MASK_8;
			sdwp_pkg::BL_PAGE: return sdwp_pkg::MASK_PAGE;
			default: return sdwp_pkg::MASK_1;
		endcase
	endfunction

	// Next column, wrapping inside the burst-aligned block.
	function automatic logic [CW-1:0] col_step(
		input logic [CW-1:0] col, input logic [CW-1:0] mask);
		return (col & ~mask) | ((col + sdwp_pkg::COL_ONE) & mask);
	endfunction

	// ------------------------------------------------------------
	// Reset release and clock-enable history
	// ------------------------------------------------------------
	// Two-stage release of the asynchronous reset.
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			rst_meta_reg <= 1'h0;
			rst_n_reg <= 1'h0;
		end
		else
		begin
			rst_meta_reg <= 1'h1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	// A low clock-enable on one edge suspends the next one.
	always_ff @(posedge SYS_CLK_I or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			cke_prev_reg <= 1'h1;
		else
			cke_prev_reg <= CKE_I; // R13 R15
	end

	assign edge_en = cke_prev_reg; // R14
	assign live = edge_en && (st_reg != sdwp_pkg::ST_PDOWN);
	assign cmd = cmd_decode(CS_N_I, RAS_N_I, CAS_N_I, WE_N_I); // R25
	assign all_sel = ADDR_I[sdwp_pkg::AP_BIT];
	assign addr_col = ADDR_I[CW-1:0];
	assign any_open = |bank_open;

	// ------------------------------------------------------------
	// Burst sequencer and store port
	// ------------------------------------------------------------
	// Decides each edge what is written and how the burst moves on.
	always_comb
	begin
		st_next = st_reg;
		bank_next = bank_reg;
		col_next = col_reg;
		rem_next = rem_reg;
		mask_next = mask_reg;
		full_next = full_reg;
		ap_next = ap_reg;
		ap_bank_next = ap_bank_reg;
		pd_act_next = pd_act_reg;
		reject_next = 1'h0;
		we_next = 1'h0;
		wbank_next = wbank_reg;
		wrow_next = wrow_reg;
		wcol_next = wcol_reg;
		wdata_next = wdata_reg;
		word_go = 1'h0;
		word_bank = bank_reg;
		word_col = col_reg;
		rec_start = 1'h0;
		pre_req = 1'h0;
		act_req = 1'h0;
		unique case (st_reg)
			sdwp_pkg::ST_PDOWN:
			begin
				// Only clock-enable with a NOP is looked at here.
				if (CKE_I && cmd == sdwp_pkg::CMD_NOP) // R20
					st_next = sdwp_pkg::ST_IDLE; // R22
			end
			sdwp_pkg::ST_IDLE, sdwp_pkg::ST_BURST:
			begin
				if (edge_en)
				begin
					unique case (cmd)
						sdwp_pkg::CMD_WRITE:
						begin
							if (bank_open[BANK_I]) // R17
							begin
								word_go = 1'h1; // R2 R5
								word_bank = BANK_I;
								word_col = addr_col;
								bank_next = BANK_I;
								mask_next = bl_mask(BURST_LEN_I);
								rem_next = mask_next;
								col_next = col_step(addr_col, mask_next);
								full_next = BURST_LEN_I == sdwp_pkg::BL_PAGE;
								ap_next = all_sel; // R1
								st_next = sdwp_pkg::ST_BURST;
								if (mask_next == sdwp_pkg::MASK_1)
								begin
									st_next = sdwp_pkg::ST_IDLE;
									rec_start = all_sel; // R1
								end
							end
							else
								reject_next = 1'h1;
						end
						sdwp_pkg::CMD_READ, sdwp_pkg::CMD_TERMINATE:
						begin
							// The word on this edge is dropped.
							if (st_reg == sdwp_pkg::ST_BURST) // R6 R11 R12
							begin
								st_next = sdwp_pkg::ST_IDLE;
								rec_start = ap_reg;
							end
						end
						sdwp_pkg::CMD_PRECHARGE:
						begin
							pre_req = 1'h1; // R16
							if (all_sel || BANK_I == bank_reg)
								st_next = sdwp_pkg::ST_IDLE;
						end
						sdwp_pkg::CMD_ACTIVE:
						begin
							if (!bank_open[BANK_I] && !bank_busy[BANK_I])
								act_req = 1'h1; // R24
							else
								reject_next = 1'h1;
						end
						default:
						begin
							// Burst words advance on NOP-like edges.
							if (st_reg == sdwp_pkg::ST_BURST)
							begin
								word_go = 1'h1; // R2
								col_next = col_step(col_reg, mask_reg); // R4
								if (!full_reg)
								begin
									rem_next = rem_reg - sdwp_pkg::COL_ONE;
									if (rem_reg == sdwp_pkg::COL_ONE)
									begin
										st_next = sdwp_pkg::ST_IDLE; // R3
										rec_start = ap_reg; // R1
									end
								end
							end
						end
					endcase
				end
				// Idle with clock-enable low and a NOP powers down.
				if (st_reg == sdwp_pkg::ST_IDLE && !CKE_I &&
					cmd == sdwp_pkg::CMD_NOP)
				begin
					st_next = sdwp_pkg::ST_PDOWN; // R18
					pd_act_next = any_open; // R19
				end
			end
			default:
				st_next = sdwp_pkg::ST_IDLE;
		endcase
		if (rec_start)
			ap_bank_next = bank_next;
		if (word_go)
		begin
			we_next = !DQM_I; // R23
			wbank_next = word_bank;
			wrow_next = bank_row[word_bank];
			wcol_next = word_col;
			wdata_next = DQ_I;
		end
		susp_next = (st_next == sdwp_pkg::ST_BURST) && !CKE_I; // R13
	end

	// Sequencer and store port registers.
	always_ff @(posedge SYS_CLK_I or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			st_reg <= sdwp_pkg::ST_IDLE;
			bank_reg <= 2'h0;
			col_reg <= sdwp_pkg::COL_ZERO;
			rem_reg <= sdwp_pkg::COL_ZERO;
			mask_reg <= sdwp_pkg::MASK_1;
			full_reg <= 1'h0;
			ap_reg <= 1'h0;
			ap_bank_reg <= 2'h0;
			pd_act_reg <= 1'h0;
			susp_reg <= 1'h0;
			reject_reg <= 1'h0;
			we_reg <= 1'h0;
			wbank_reg <= 2'h0;
			wrow_reg <= 12'h000;
			wcol_reg <= sdwp_pkg::COL_ZERO;
			wdata_reg <= 8'h00;
		end
		else
		begin
			st_reg <= st_next;
			bank_reg <= bank_next;
			col_reg <= col_next;
			rem_reg <= rem_next;
			mask_reg <= mask_next;
			full_reg <= full_next;
			ap_reg <= ap_next;
			ap_bank_reg <= ap_bank_next;
			pd_act_reg <= pd_act_next;
			susp_reg <= susp_next;
			reject_reg <= reject_next;
			we_reg <= we_next;
			wbank_reg <= wbank_next;
			wrow_reg <= wrow_next;
			wcol_reg <= wcol_next;
			wdata_reg <= wdata_next;
		end
	end

	// ------------------------------------------------------------
	// Bank state
	// ------------------------------------------------------------
	// Each bank keeps its open row and its precharge hold-off.
	genvar g;
	generate
		for (g = 0; g < NB; g++)
		begin : g_bank
			localparam logic [BW-1:0] IDX = BW'(g);
			logic open_reg, open_next;
			logic close_now;
			logic [sdwp_pkg::CNT_W-1:0] cnt_reg, cnt_next;
			logic [RW-1:0] row_reg, row_next;

			// Close on precharge, open on ACTIVE.
			always_comb
			begin
				close_now = (pre_req && (all_sel || BANK_I == IDX)) ||
					(rec_done && ap_bank_reg == IDX); // R8 R16
				open_next = open_reg;
				row_next = row_reg;
				cnt_next = cnt_reg;
				if (cnt_reg != sdwp_pkg::CNT_ZERO)
					cnt_next = cnt_reg - sdwp_pkg::CNT_ONE;
				if (close_now)
				begin
					open_next = 1'h0; // R16 R17
					cnt_next = sdwp_pkg::ROW_PRE_LOAD; // R10
				end
				else if (act_req && BANK_I == IDX)
				begin
					open_next = 1'h1; // R24
					row_next = ADDR_I;
				end
			end

			// Bank registers.
			always_ff @(posedge SYS_CLK_I or negedge rst_n_reg)
			begin
				if (!rst_n_reg)
				begin
					open_reg <= 1'h0;
					cnt_reg <= sdwp_pkg::CNT_ZERO;
					row_reg <= 12'h000;
				end
				else
				begin
					open_reg <= open_next;
					cnt_reg <= cnt_next;
					row_reg <= row_next;
				end
			end

			assign bank_open[g] = open_reg;
			assign bank_busy[g] = cnt_reg != sdwp_pkg::CNT_ZERO;
			assign bank_row[g] = row_reg;
		end
	endgenerate

	// Write recovery before the auto precharge.
	sdwp_recovery_timer #(
		.CYC(sdwp_pkg::WR_REC_CYC)
	) u_recovery (
		.clk_i(SYS_CLK_I),
		.rst_n_i(rst_n_reg),
		.start_i(rec_start),
		.done_o(rec_done)
	);

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Write-only core: the data pins are never driven.
	assign DQ_O = 8'h00; // R3 R20
	assign DQ_OE_O = 1'h0; // R3
	assign MEM_WE_O = we_reg;
	assign MEM_BANK_O = wbank_reg;
	assign MEM_ROW_O = wrow_reg;
	assign MEM_COL_O = wcol_reg;
	assign MEM_DATA_O = wdata_reg;
	assign BANK_OPEN_O = bank_open;
	assign SUSPEND_O = susp_reg;
	assign PDOWN_O = (st_reg == sdwp_pkg::ST_PDOWN);
	assign PDOWN_ACTIVE_O = pd_act_reg;
	assign CMD_REJECT_O = reject_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!rst_n_reg);

	a_first_word: assert property ( // R2
		live && cmd == sdwp_pkg::CMD_WRITE && bank_open[BANK_I] && !DQM_I
		|=> MEM_WE_O && MEM_COL_O == $past(addr_col)
		&& MEM_DATA_O == $past(DQ_I))
		else $error("write word not stored at command edge");
	a_mask_blocks: assert property (live && DQM_I |=> !MEM_WE_O) // R23
		else $error("masked word was stored");
	a_term_prev: assert property ( // R12
		(live && st_reg == sdwp_pkg::ST_BURST && cmd == sdwp_pkg::CMD_NOP
		&& !DQM_I) ##1 (live && cmd == sdwp_pkg::CMD_TERMINATE)
		|-> MEM_WE_O ##1 (!MEM_WE_O && st_reg == sdwp_pkg::ST_IDLE))
		else $error("burst terminate stored the wrong words");
	a_read_stop: assert property ( // R6
		live && cmd == sdwp_pkg::CMD_READ && st_reg == sdwp_pkg::ST_BURST
		|=> st_reg == sdwp_pkg::ST_IDLE && !MEM_WE_O)
		else $error("read did not stop the write burst");
	a_suspend_hold: assert property ( // R14
		st_reg == sdwp_pkg::ST_BURST && !CKE_I
		|=> ##1 (!MEM_WE_O && $stable(col_reg)))
		else $error("suspended edge advanced the burst");
	a_fixed_end: assert property ( // R3
		(live && cmd == sdwp_pkg::CMD_WRITE && bank_open[BANK_I]
		&& BURST_LEN_I == sdwp_pkg::BL_4)
		##1 (live && cmd == sdwp_pkg::CMD_NOP) [*3]
		|=> st_reg == sdwp_pkg::ST_IDLE)
		else $error("burst of four did not end");
	a_page_wrap: assert property ( // R4
		live && st_reg == sdwp_pkg::ST_BURST && full_reg
		&& cmd == sdwp_pkg::CMD_NOP && col_reg == sdwp_pkg::COL_LAST
		|=> col_reg == sdwp_pkg::COL_ZERO && st_reg == sdwp_pkg::ST_BURST)
		else $error("full page burst did not wrap");
	a_ap_recovery: assert property ( // R8
		rec_start |=> bank_open[ap_bank_reg] [*2]
		##1 !bank_open[ap_bank_reg])
		else $error("auto precharge not after recovery time");
	a_all_close: assert property ( // R16
		live && cmd == sdwp_pkg::CMD_PRECHARGE && all_sel
		|=> BANK_OPEN_O == 4'h0)
		else $error("all-bank precharge left a bank open");
	a_closed_reject: assert property ( // R17
		live && cmd == sdwp_pkg::CMD_WRITE && !bank_open[BANK_I]
		|=> !MEM_WE_O && CMD_REJECT_O)
		else $error("write to an idle bank was accepted");
	a_pdown_entry: assert property ( // R18
		st_reg == sdwp_pkg::ST_IDLE && !CKE_I && cmd == sdwp_pkg::CMD_NOP
		|=> PDOWN_O && PDOWN_ACTIVE_O == $past(any_open))
		else $error("power-down not entered");
	a_pdown_exit: assert property ( // R22
		PDOWN_O && CKE_I && cmd == sdwp_pkg::CMD_NOP
		|=> !PDOWN_O ##1 !SUSPEND_O)
		else $error("power-down not left");

	c_page_wrap: cover property (full_reg && col_reg == sdwp_pkg::COL_LAST
		&& live && st_reg == sdwp_pkg::ST_BURST);
	c_suspend: cover property (SUSPEND_O ##1 SUSPEND_O);
	c_active_pd: cover property (PDOWN_O && PDOWN_ACTIVE_O);
	c_ap_done: cover property (rec_done);

endmodule

// >>> bench/sdwp_ctl_model.sv
// Purpose: Controller model driving command, data, mask and clock enable.
// Assumes: Pins change by non-blocking assignment at a rising edge.
// Notes: Pins hold between calls, so each task leaves a defined command.

`timescale 1ns/10ps
module sdwp_ctl_model (
	input wire logic clk_i,
	output logic cke_o,
	output logic cs_n_o,
	output logic [2:0] cmd_o,
	output logic [1:0] bank_o,
	output logic [11:0] addr_o,
	output logic dqm_o,
	output logic [7:0] dq_o,
	output logic [2:0] bl_o
);
	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	// Start deselected, masked and with clock enable high.
	initial
	begin
		{cke_o, cs_n_o, cmd_o, dqm_o} = 6'h3F;
		{bank_o, addr_o, dq_o, bl_o} = 25'h0000000;
	end

	// Present one command with its data and clock enable for one edge.
	task automatic op(input logic [2:0] c, input logic [1:0] b,
		input logic [11:0] a, input logic m, input logic [7:0] d,
		input logic k);
		@(posedge clk_i);
		cs_n_o <= 1'h0;
		cmd_o <= c;
		bank_o <= b;
		addr_o <= a;
		dqm_o <= m;
		dq_o <= d;
		cke_o <= k;
	endtask

	// Idle edges; data is inverted so a stale word never looks valid.
	task automatic nop(input int n);
		repeat (n)
			op(sdwp_pkg::CMD_NOP, 2'h0, 12'h000, 1'h1, ~dq_o, 1'h1);
	endtask

	// Burst length changes on a deselected edge only.
	task automatic set_bl(input logic [2:0] v);
		@(posedge clk_i);
		cs_n_o <= 1'h1;
		bl_o <= v;
	endtask

	// Close banks: wait recovery, mask both edges, then hold off.
	task automatic pre(input logic [1:0] b, input logic [11:0] a);
		nop(sdwp_pkg::WR_REC_CYC);
		op(sdwp_pkg::CMD_NOP, b, a, 1'h1, 8'h00, 1'h1);
		op(sdwp_pkg::CMD_PRECHARGE, b, a, 1'h1, 8'h00, 1'h1);
		nop(sdwp_pkg::ROW_PRE_CYC);
	endtask
endmodule

// >>> bench/sdwp_write_core_bench.sv
// Purpose: Self-checking bench for the write burst memory core.
// Assumes: 125 MHz clock; the controller model drives every pin but the clock and the reset.
// Notes: A monitor records each stored word for the scenarios to judge.

`timescale 1ns/10ps
module sdwp_write_core_bench;
	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	localparam logic [2:0] C_WR = sdwp_pkg::CMD_WRITE;
	localparam logic [2:0] C_RD = sdwp_pkg::CMD_READ;
	localparam logic [2:0] C_ACT = sdwp_pkg::CMD_ACTIVE;
	localparam logic [2:0] C_TRM = sdwp_pkg::CMD_TERMINATE;
	localparam logic [2:0] C_NOP = sdwp_pkg::CMD_NOP;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic cke, cs_n, dqm, mem_we, rej, pd, pd_act, dq_oe, susp;
	logic [2:0] cmd, bl;
	logic [1:0] bank, mbank;
	logic [11:0] addr, mrow;
	logic [7:0] dq, mdata, dq_out;
	logic [9:0] mcol;
	logic [3:0] bopen;
	logic [9:0] cq[$];
	logic [7:0] wq[$];
	int miscompares = 0;
	int n_compared = 0;

	sdwp_ctl_model sdwp_ctl_model_i (.clk_i(clk), .cke_o(cke),
		.cs_n_o(cs_n), .cmd_o(cmd), .bank_o(bank), .addr_o(addr),
		.dqm_o(dqm), .dq_o(dq), .bl_o(bl));

	sdwp_write_core sdwp_write_core_i (.SYS_CLK_I(clk), .RESETN_I(rst_n),
		.CKE_I(cke), .CS_N_I(cs_n), .RAS_N_I(cmd[2]), .CAS_N_I(cmd[1]),
		.WE_N_I(cmd[0]), .BANK_I(bank), .ADDR_I(addr), .DQM_I(dqm),
		.DQ_I(dq), .BURST_LEN_I(bl), .DQ_O(dq_out), .DQ_OE_O(dq_oe),
		.MEM_WE_O(mem_we), .MEM_BANK_O(mbank), .MEM_ROW_O(mrow),
		.MEM_COL_O(mcol), .MEM_DATA_O(mdata), .BANK_OPEN_O(bopen),
		.SUSPEND_O(susp), .PDOWN_O(pd), .PDOWN_ACTIVE_O(pd_act),
		.CMD_REJECT_O(rej));

	// Clock of 8 ns period.
	always #4 clk = ~clk;

	// Record every stored word in order.
	always @(posedge clk)
	begin
		if (mem_we === 1'h1)
		begin
			cq.push_back(mcol);
			wq.push_back(mdata);
		end
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Count and compare one value.
	task automatic chk(input string s, input logic [11:0] e,
		input logic [11:0] g);
		n_compared++;
		if (g !== e)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask

	// Compare stored word i with the expected column and data.
	task automatic word(input int i, input logic [9:0] c,
		input logic [7:0] d);
		chk("store column", {2'h0, c}, {2'h0, cq[i]});
		chk("store data", {4'h0, d}, {4'h0, wq[i]});
	endtask

	// Compare the number of stored words.
	task automatic count(input logic [11:0] n);
		chk("stored words", n, 12'(cq.size()));
	endtask

	// Forget stored words at a quiet moment between edges.
	task automatic fresh;
		@(negedge clk);
		cq.delete();
		wq.delete();
	endtask

	// One data edge carrying no command.
	task automatic dat(input logic [7:0] d, input logic m, input logic k);
		sdwp_ctl_model_i.op(C_NOP, 2'h0, 12'h000, m, d, k);
	endtask

	// One unmasked write edge with clock enable high.
	task automatic wr(input logic [1:0] b, input logic [11:0] a,
		input logic [7:0] d);
		sdwp_ctl_model_i.op(C_WR, b, a, 1'h0, d, 1'h1);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Four word burst, a dropped fifth word, then a suspended edge.
	task automatic t_burst;
		sdwp_ctl_model_i.set_bl(sdwp_pkg::BL_4);
		sdwp_ctl_model_i.op(C_ACT, 2'h0, 12'h005, 1'h1, 8'h00, 1'h1);
		sdwp_ctl_model_i.nop(3);
		chk("open banks", 12'h001, {8'h00, bopen});
		fresh();
		wr(2'h0, 12'h008, 8'hA0);
		for (int i = 1; i < 5; i++)
			dat(8'hA0 + 8'(i), 1'h0, 1'h1);
		chk("data pins", 12'h000, {3'h0, dq_oe, dq_out});
		wr(2'h0, 12'h050, 8'hE0);
		dat(8'hE1, 1'h0, 1'h0);
		dat(8'hE2, 1'h0, 1'h1);
		@(negedge clk);
		chk("suspend", 12'h001, {11'h000, susp});
		dat(8'hE3, 1'h0, 1'h1);
		dat(8'hE4, 1'h0, 1'h1);
		sdwp_ctl_model_i.nop(3);
		count(12'h008);
		for (int i = 0; i < 4; i++)
			word(i, 10'h008 + 10'(i), 8'hA0 + 8'(i));
		word(4, 10'h050, 8'hE0);
		word(5, 10'h051, 8'hE1);
		word(6, 10'h052, 8'hE3);
		word(7, 10'h053, 8'hE4);
		$display("test burst done");
	endtask

	// Masked word and terminate in a fixed and a full page burst.
	task automatic t_term;
		sdwp_ctl_model_i.set_bl(sdwp_pkg::BL_8);
		fresh();
		wr(2'h0, 12'h010, 8'hB0);
		dat(8'hB1, 1'h1, 1'h1);
		dat(8'hB2, 1'h0, 1'h1);
		sdwp_ctl_model_i.op(C_TRM, 2'h0, 12'h000, 1'h0, 8'hB3, 1'h1);
		sdwp_ctl_model_i.set_bl(sdwp_pkg::BL_PAGE);
		wr(2'h0, 12'h3FE, 8'hF0);
		dat(8'hF1, 1'h0, 1'h1);
		dat(8'hF2, 1'h0, 1'h1);
		sdwp_ctl_model_i.op(C_TRM, 2'h0, 12'h000, 1'h0, 8'hF3, 1'h1);
		sdwp_ctl_model_i.nop(2);
		count(12'h005);
		word(0, 10'h010, 8'hB0);
		word(1, 10'h012, 8'hB2);
		word(2, 10'h3FE, 8'hF0);
		word(4, 10'h000, 8'hF2);
		$display("test terminate done");
	endtask

	// Back to back writes own their data; a read cuts the last burst.
	task automatic t_wr2wr;
		sdwp_ctl_model_i.set_bl(sdwp_pkg::BL_2);
		fresh();
		wr(2'h0, 12'h020, 8'hC0);
		wr(2'h0, 12'h030, 8'hC1);
		dat(8'hC2, 1'h0, 1'h1);
		dat(8'hC3, 1'h0, 1'h1);
		wr(2'h0, 12'h040, 8'hD0);
		sdwp_ctl_model_i.op(C_RD, 2'h0, 12'h040, 1'h0, 8'hD1, 1'h1);
		dat(8'hD2, 1'h0, 1'h1);
		sdwp_ctl_model_i.nop(2);
		count(12'h004);
		word(0, 10'h020, 8'hC0);
		word(1, 10'h030, 8'hC1);
		word(2, 10'h031, 8'hC2);
		word(3, 10'h040, 8'hD0);
		$display("test write to write done");
	endtask

	// All-bank precharge, then a write to a closed bank is refused.
	task automatic t_pre;
		sdwp_ctl_model_i.op(C_ACT, 2'h1, 12'h009, 1'h1, 8'h00, 1'h1);
		sdwp_ctl_model_i.nop(3);
		sdwp_ctl_model_i.pre(2'h0, 12'h400);
		fresh();
		chk("open banks", 12'h000, {8'h00, bopen});
		wr(2'h0, 12'h060, 8'h11);
		dat(8'h12, 1'h0, 1'h1);
		@(negedge clk);
		chk("reject", 12'h001, {11'h000, rej});
		sdwp_ctl_model_i.nop(2);
		count(12'h000);
		$display("test precharge done");
	endtask

	// Active power-down, ignored write, exit, then auto precharge.
	task automatic t_pdown;
		sdwp_ctl_model_i.op(C_ACT, 2'h2, 12'h007, 1'h1, 8'h00, 1'h1);
		sdwp_ctl_model_i.nop(3);
		fresh();
		dat(8'h21, 1'h1, 1'h0);
		sdwp_ctl_model_i.op(C_WR, 2'h2, 12'h000, 1'h0, 8'h22, 1'h0);
		@(negedge clk);
		chk("power down", 12'h001, {11'h000, pd});
		chk("active power down", 12'h001, {11'h000, pd_act});
		dat(8'h23, 1'h1, 1'h1);
		sdwp_ctl_model_i.nop(2);
		@(negedge clk);
		chk("power down", 12'h000, {11'h000, pd});
		count(12'h000);
		chk("open banks", 12'h004, {8'h00, bopen});
		sdwp_ctl_model_i.set_bl(sdwp_pkg::BL_1);
		wr(2'h2, 12'h43C, 8'h31);
		sdwp_ctl_model_i.nop(2);
		@(negedge clk);
		chk("open banks", 12'h004, {8'h00, bopen});
		sdwp_ctl_model_i.nop(3);
		@(negedge clk);
		chk("open banks", 12'h000, {8'h00, bopen});
		word(0, 10'h03C, 8'h31);
		chk("store row", 12'h007, mrow);
		chk("store bank", 12'h002, {10'h000, mbank});
		$display("test power down done");
	endtask

	// ------------------------------------------------------------
	// Run control
	// ------------------------------------------------------------
	// Print the counts and the verdict, then stop.
	task automatic report_and_stop;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Main sequence after reset.
	initial
	begin
		repeat (5) @(posedge clk);
		rst_n <= 1'h1;
		repeat (2) @(posedge clk);
		t_burst();
		t_term();
		t_wr2wr();
		t_pre();
		t_pdown();
		report_and_stop();
	end

	// Cut a hang short well past the expected run of under a hundred cycles.
	initial
	begin
		#(8 * 1000);
		miscompares++;
		report_and_stop();
	end
endmodule
